/* shared/hasc_pkg.sv */
// Constants shared by the hearing-aid audio chain
package hasc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS  = 4;
  localparam int unsigned P32_NS  = 31250;
  localparam int unsigned P16_NS  = 62500;
  localparam int unsigned CNT_W   = 14;
  // ----------------------------------------------------------------
  // Data path shape
  // ----------------------------------------------------------------
  localparam int unsigned DW      = 20;
  localparam int unsigned NSEC    = 8;
  localparam int unsigned NCOEF   = 5;
  localparam int unsigned COEF_Q  = 14;
  localparam int unsigned GAIN_Q  = 15;
  localparam int unsigned WBG_Q   = 12;
  localparam int unsigned LEAK_SH = 8;
  localparam int unsigned ENV_SH  = 6;
  localparam int unsigned NSH_SH  = 2;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] A_CTRL  = 12'h000;
  localparam logic [11:0] A_STAT  = 12'h004;
  localparam logic [11:0] A_WBG   = 12'h008;
  localparam logic [11:0] A_VOL   = 12'h00C;
  localparam logic [11:0] A_NZ    = 12'h010;
  localparam logic [11:0] A_CLIP  = 12'h014;
  localparam logic [11:0] A_THR   = 12'h018;
  localparam logic [11:0] A_NRA   = 12'h01C;
  localparam logic [11:0] A_SCNT  = 12'h020;
  localparam logic [11:0] A_COEF  = 12'h100;
  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int unsigned F_SRC   = 0;
  localparam int unsigned F_SUM2  = 1;
  localparam int unsigned F_R16   = 2;
  localparam int unsigned F_NPT   = 3;
  localparam int unsigned F_CH    = 5;
  // ----------------------------------------------------------------
  // Reset values, compressor gain floor and step
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_WBG  = 16'h1000;
  localparam logic [15:0] RST_VOL  = 16'h7FFF;
  localparam logic [15:0] RST_NZ   = 16'h0000;
  localparam logic [19:0] RST_CLIP = 20'h7FFFF;
  localparam logic [19:0] RST_THR  = 20'h40000;
  localparam logic [15:0] RST_NRA  = 16'h7FFF;
  localparam logic [3:0]  RST_CH   = 4'h8;
  localparam logic [15:0] RST_B0   = 16'h4000;
  localparam logic [15:0] GAIN_MIN = 16'h0800;
  localparam logic [15:0] GAIN_STP = 16'h0010;
  localparam logic [19:0] LFSR_SEED = 20'h00001;
  // Noise injection point
  typedef enum logic [1:0] {
    HASC_NZ_OFF  = 2'b00,
    HASC_NZ_PRE  = 2'b01,
    HASC_NZ_POST = 2'b10
  } hasc_npt_e;
endpackage : hasc_pkg

/* src/hasc_chain.sv */
// Hearing-aid audio chain with AHB-Lite register slave
// Function
// - The second input is picked between second mic and telecoil by a control bit.
// - The front microphone is always the primary input of the chain.
// - Samples are 20-bit and arrive at a selectable 32 kHz or 16 kHz rate.
// - Samples pass an IIR stage then four shaping biquads in fixed order.
// - Channel processing is one wideband compressor; the 1, 2, 4, 6 or 8 channel count is held but does not split the signal.
// - Noise reduction is a single wideband attenuation set by the NRA register.
// - Two late biquads follow synthesis before the output gain stage.
// - The output gain stage applies wideband gain then volume attenuation.
// - Two final biquads follow, then a peak clipper bounds the magnitude.
// - The output converter is fed by the peak clipper.
// - Shaped attenuated noise may be added before volume or before the clipper.
module hasc_chain #(
  parameter int unsigned TICKS_32 = hasc_pkg::P32_NS / hasc_pkg::CLK_NS,
  parameter int unsigned TICKS_16 = hasc_pkg::P16_NS / hasc_pkg::CLK_NS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [19:0] mic1_in,
  input  wire logic [19:0] mic2_in,
  input  wire logic [19:0] coil_in,
  output logic      [19:0] dac_data,
  output logic             dac_valid
);
  localparam int unsigned NC = hasc_pkg::NSEC * hasc_pkg::NCOEF;

  // ----------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------
  function automatic logic signed [39:0] prod(
    input logic signed [19:0] x,
    input logic signed [15:0] c);
    prod = 40'(x * c);
  endfunction : prod

  function automatic logic signed [19:0] sat20(
    input logic signed [39:0] v);
    if (v > 40'sd524287)
      sat20 = 20'sh7FFFF;
    else if (v < -40'sd524288)
      sat20 = -20'sh80000;
    else
      sat20 = v[19:0];
  endfunction : sat20

  function automatic logic signed [19:0] mulg(
    input logic signed [19:0] x,
    input logic        [15:0] g,
    input int unsigned        sh);
    mulg = sat20(prod(x, $signed({1'b0, g[14:0]})) >>> sh);
  endfunction : mulg

  function automatic logic [19:0] mag(input logic signed [19:0] x);
    mag = x[19] ? 20'(-x) : x;
  endfunction : mag

  function automatic logic chan_ok(input logic [3:0] n);
    chan_ok = (n == 4'h1) || (n == 4'h2) || (n == 4'h4) ||
              (n == 4'h6) || (n == 4'h8);
  endfunction : chan_ok

  function automatic logic is_coef(input logic [11:0] a);
    is_coef = (a >= hasc_pkg::A_COEF) &&
              (a < 12'(hasc_pkg::A_COEF + 4 * NC));
  endfunction : is_coef

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic               src_r, sum2_r, r16_r;
  logic [1:0]         npt_r;
  logic [3:0]         ch_r;
  logic [15:0]        wbg_r, vol_r, nz_r, nra_r;
  logic [19:0]        clip_r, thr_r;
  logic signed [15:0] coef_r [NC];
  logic [31:0]        scnt_r;
  logic               wpend_r;
  logic [11:0]        wadr_r;
  logic [31:0]        hrdata_r;

  assign hrdata = hrdata_r;

  // ----------------------------------------------------------------
  // Bus slave, zero wait state
  // ----------------------------------------------------------------
  logic        take;
  logic [11:0] ra;
  logic [5:0]  ci;
  logic [5:0]  wci;
  assign take = hsel && htrans[1] && hready;
  assign ra   = {haddr[11:2], 2'b00};
  assign ci   = 6'((ra - hasc_pkg::A_COEF) >> 2);
  assign wci  = 6'((wadr_r - hasc_pkg::A_COEF) >> 2);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wpend_r <= 1'b0;
      wadr_r  <= 12'h000;
    end else begin
      wpend_r <= take && hwrite;
      if (take)
        wadr_r <= ra;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (take && !hwrite) begin
      if (is_coef(ra))
        hrdata_r <= 32'($signed(coef_r[ci]));
      else
        case (ra)
          hasc_pkg::A_CTRL: hrdata_r <= {23'h0, ch_r, npt_r,
                                         r16_r, sum2_r, src_r};
          hasc_pkg::A_STAT: hrdata_r <= {12'h000, dac_data};
          hasc_pkg::A_WBG:  hrdata_r <= {16'h0000, wbg_r};
          hasc_pkg::A_VOL:  hrdata_r <= {16'h0000, vol_r};
          hasc_pkg::A_NZ:   hrdata_r <= {16'h0000, nz_r};
          hasc_pkg::A_CLIP: hrdata_r <= {12'h000, clip_r};
          hasc_pkg::A_THR:  hrdata_r <= {12'h000, thr_r};
          hasc_pkg::A_NRA:  hrdata_r <= {16'h0000, nra_r};
          hasc_pkg::A_SCNT: hrdata_r <= scnt_r;
          default:          hrdata_r <= 32'h00000000;
        endcase
    end
  end

  // Writes land at the end of the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_r  <= 1'b0;
      sum2_r <= 1'b0;
      r16_r  <= 1'b0;
      npt_r  <= hasc_pkg::HASC_NZ_OFF;
      ch_r   <= hasc_pkg::RST_CH;
      wbg_r  <= hasc_pkg::RST_WBG;
      vol_r  <= hasc_pkg::RST_VOL;
      nz_r   <= hasc_pkg::RST_NZ;
      clip_r <= hasc_pkg::RST_CLIP;
      thr_r  <= hasc_pkg::RST_THR;
      nra_r  <= hasc_pkg::RST_NRA;
    end else if (wpend_r) begin
      case (wadr_r)
        hasc_pkg::A_CTRL: begin
          src_r  <= hwdata[hasc_pkg::F_SRC];
          sum2_r <= hwdata[hasc_pkg::F_SUM2];
          r16_r  <= hwdata[hasc_pkg::F_R16];
          npt_r  <= hwdata[hasc_pkg::F_NPT +: 2];
          // Illegal channel counts keep the old value
          if (chan_ok(hwdata[hasc_pkg::F_CH +: 4]))
            ch_r <= hwdata[hasc_pkg::F_CH +: 4];
        end
        hasc_pkg::A_WBG:  wbg_r  <= hwdata[15:0];
        hasc_pkg::A_VOL:  vol_r  <= hwdata[15:0];
        hasc_pkg::A_NZ:   nz_r   <= hwdata[15:0];
        hasc_pkg::A_CLIP: clip_r <= {1'b0, hwdata[18:0]};
        hasc_pkg::A_THR:  thr_r  <= {1'b0, hwdata[18:0]};
        hasc_pkg::A_NRA:  nra_r  <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NC; i++)
        coef_r[i] <= (i % hasc_pkg::NCOEF == 0) ?
                     hasc_pkg::RST_B0 : 16'h0000;
    end else if (wpend_r && is_coef(wadr_r)) begin
      coef_r[wci] <= hwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Sample tick
  // ----------------------------------------------------------------
  logic [hasc_pkg::CNT_W-1:0] cnt_r, lim;
  logic                       tick_r;
  assign lim = r16_r ? hasc_pkg::CNT_W'(TICKS_16 - 1) :
                       hasc_pkg::CNT_W'(TICKS_32 - 1);

  // Wrap also on >= so a rate change never strands the counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
      scnt_r <= 32'h00000000;
    end else begin
      tick_r <= (cnt_r >= lim);
      cnt_r  <= (cnt_r >= lim) ? '0 : cnt_r + 1'b1;
      if (tick_r)
        scnt_r <= scnt_r + 32'h00000001;
    end
  end

  // ----------------------------------------------------------------
  // Converter inputs, two-flop synchronised
  // ----------------------------------------------------------------
  logic [19:0] m1_q, m2_q, tc_q, m1_s, m2_s, tc_s;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {m1_q, m2_q, tc_q} <= '0;
      {m1_s, m2_s, tc_s} <= '0;
    end else begin
      {m1_q, m2_q, tc_q} <= {mic1_in, mic2_in, coil_in};
      {m1_s, m2_s, tc_s} <= {m1_q, m2_q, tc_q};
    end
  end

  // ----------------------------------------------------------------
  // Front end: select, leak IIR
  // ----------------------------------------------------------------
  logic signed [19:0] sec, in_r, xp_r, iir_r;
  logic signed [20:0] mix;
  assign sec = src_r ? tc_s : m2_s;
  assign mix = 21'($signed(m1_s)) + 21'(sec);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_r  <= '0;
      xp_r  <= '0;
      iir_r <= '0;
    end else if (tick_r) begin
      // Front mic always feeds; second source only adds when enabled
      in_r  <= sum2_r ? mix[20:1] : m1_s;
      xp_r  <= in_r;
      iir_r <= sat20(40'(in_r) - 40'(xp_r) + 40'(iir_r) -
                     40'(iir_r >>> hasc_pkg::LEAK_SH));
    end
  end

  // ----------------------------------------------------------------
  // Biquad sections, one register stage each
  // ----------------------------------------------------------------
  logic signed [19:0] bq_in [hasc_pkg::NSEC];
  logic signed [19:0] bq_y  [hasc_pkg::NSEC];
  logic signed [19:0] cmp_r, syn_r, wb_r, vo_r, clp_r;

  // Fixed wiring keeps stage order and latency constant
  assign bq_in[0] = iir_r;
  assign bq_in[1] = bq_y[0];
  assign bq_in[2] = bq_y[1];
  assign bq_in[3] = bq_y[2];
  assign bq_in[4] = syn_r;
  assign bq_in[5] = bq_y[4];
  assign bq_in[6] = vo_r;
  assign bq_in[7] = bq_y[6];

  genvar s;
  generate
    for (s = 0; s < hasc_pkg::NSEC; s++) begin : g_bq
      localparam int unsigned B = s * hasc_pkg::NCOEF;
      logic signed [19:0] x1, x2, y2;
      logic signed [39:0] acc;
      assign acc = prod(bq_in[s], coef_r[B])
                 + prod(x1, coef_r[B + 1])
                 + prod(x2, coef_r[B + 2])
                 - prod(bq_y[s], coef_r[B + 3])
                 - prod(y2, coef_r[B + 4]);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          x1      <= '0;
          x2      <= '0;
          y2      <= '0;
          bq_y[s] <= '0;
        end else if (tick_r) begin
          x1      <= bq_in[s];
          x2      <= x1;
          y2      <= bq_y[s];
          bq_y[s] <= sat20(acc >>> hasc_pkg::COEF_Q);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Channel processing: envelope compressor, noise attenuation
  // ----------------------------------------------------------------
  // Wideband stand-in for the band split; the channel count is held
  // for software but does not split the signal.
  logic [19:0] env_r;
  logic [15:0] gn_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      env_r <= '0;
      gn_r  <= hasc_pkg::RST_VOL;
      cmp_r <= '0;
      syn_r <= '0;
    end else if (tick_r) begin
      if (mag(bq_y[3]) > env_r)
        env_r <= mag(bq_y[3]);
      else
        env_r <= env_r - (env_r >> hasc_pkg::ENV_SH);
      if (env_r > thr_r && gn_r > hasc_pkg::GAIN_MIN)
        gn_r <= gn_r - hasc_pkg::GAIN_STP;
      else if (env_r <= thr_r && gn_r < hasc_pkg::RST_VOL)
        gn_r <= gn_r + 16'h0001;
      cmp_r <= mulg(bq_y[3], gn_r, hasc_pkg::GAIN_Q);
      syn_r <= mulg(cmp_r, nra_r, hasc_pkg::GAIN_Q);
    end
  end

  // ----------------------------------------------------------------
  // Noise source
  // ----------------------------------------------------------------
  logic [19:0]        lfsr_r;
  logic signed [19:0] nsh_r, nzv, nz_a, nz_b;
  assign nzv  = mulg(nsh_r, nz_r, hasc_pkg::GAIN_Q);
  assign nz_a = (npt_r == hasc_pkg::HASC_NZ_PRE)  ? nzv : '0;
  assign nz_b = (npt_r == hasc_pkg::HASC_NZ_POST) ? nzv : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lfsr_r <= hasc_pkg::LFSR_SEED;
      nsh_r  <= '0;
    end else if (tick_r) begin
      lfsr_r <= {lfsr_r[18:0], lfsr_r[19] ^ lfsr_r[16]};
      // One-pole low-pass shapes the white source
      nsh_r  <= sat20(40'(nsh_r) + (40'($signed(lfsr_r) - nsh_r)
                       >>> hasc_pkg::NSH_SH));
    end
  end

  // ----------------------------------------------------------------
  // Output gain, clipper, converter feed
  // ----------------------------------------------------------------
  logic signed [19:0] pv, pc, lvl;
  assign pv  = sat20(40'(wb_r) + 40'(nz_a));
  assign pc  = sat20(40'(bq_y[7]) + 40'(nz_b));
  assign lvl = $signed(clip_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wb_r      <= '0;
      vo_r      <= '0;
      clp_r     <= '0;
      dac_data  <= '0;
      dac_valid <= 1'b0;
    end else begin
      dac_valid <= tick_r;
      if (tick_r) begin
        wb_r  <= sat20(prod(bq_y[5], $signed(wbg_r))
                       >>> hasc_pkg::WBG_Q);
        vo_r  <= mulg(pv, vol_r, hasc_pkg::GAIN_Q);
        if (pc > lvl)
          clp_r <= lvl;
        else if (pc < -lvl)
          clp_r <= -lvl;
        else
          clp_r <= pc;
        dac_data <= clp_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [15:0] gap_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      gap_r <= 16'h0000;
    else
      gap_r <= tick_r ? 16'h0000 : gap_r + 16'h0001;
  end

  // Level that was in force when the sample now on the output was clipped
  logic [19:0] lv1_r, lv2_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lv1_r <= hasc_pkg::RST_CLIP;
      lv2_r <= hasc_pkg::RST_CLIP;
    end else if (tick_r) begin
      lv1_r <= clip_r;
      lv2_r <= lv1_r;
    end
  end

  clip_bound_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $signed(dac_data) <= $signed(lv2_r) &&
    $signed(dac_data) >= -$signed(lv2_r))
    else $error("clipper output above level");

  tick_period_a: assert property (@(posedge hclk) disable iff (!hresetn)
    gap_r < 16'(TICKS_16 + 1))
    else $error("sample tick missing");

  one_valid_a: assert property (@(posedge hclk) disable iff (!hresetn)
    dac_valid |-> $past(tick_r) ##1 !dac_valid)
    else $error("output strobe not single");

  src_pick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(tick_r) && !$past(sum2_r) |-> in_r == $past(m1_s))
    else $error("primary input not taken");

  stage_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !$past(tick_r) |-> $stable(iir_r) && $stable(bq_y[7]))
    else $error("stage moved off tick");

  chan_legal_a: assert property (@(posedge hclk) disable iff (!hresetn)
    chan_ok(ch_r))
    else $error("illegal channel count");

  dac_feed_a: assert property (@(posedge hclk) disable iff (!hresetn)
    dac_valid |-> dac_data == $past(clp_r))
    else $error("converter not fed by clipper");

  noise_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    npt_r == hasc_pkg::HASC_NZ_OFF |-> nz_a == 0 && nz_b == 0)
    else $error("noise injected while off");
endmodule : hasc_chain

/* sim/hasc_audio_model.sv */
// Far-side model: sample sources and output converter monitor
module hasc_audio_model #(
  parameter logic [19:0] AMP = 20'h10000
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clr,
  input  wire logic [2:0]  en,
  input  wire logic [19:0] dac_data,
  input  wire logic        dac_valid,
  output logic      [19:0] mic1_in,
  output logic      [19:0] mic2_in,
  output logic      [19:0] coil_in,
  output logic      [19:0] peak,
  output logic      [15:0] gap
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        phase;
  logic [15:0] cnt;
  logic [19:0] mag;
  logic [19:0] wave;
  // --------------------------------------------------------------
  // Sources: square wave, so the DC blocker never hides the input
  // --------------------------------------------------------------
  assign wave    = phase ? AMP : -AMP;
  assign mic1_in = en[0] ? wave : 20'h00000;
  assign mic2_in = en[1] ? wave : 20'h00000;
  assign coil_in = en[2] ? wave : 20'h00000;
  assign mag     = dac_data[19] ? -dac_data : dac_data;
  // --------------------------------------------------------------
  // Converter side: peak magnitude and spacing of samples
  // --------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= 1'b0;
      cnt   <= 16'h0000;
      gap   <= 16'h0000;
      peak  <= 20'h00000;
    end else begin
      cnt <= cnt + 16'h0001;
      if (dac_valid) begin
        phase <= ~phase;
        gap   <= cnt + 16'h0001;
        cnt   <= 16'h0000;
        if (mag > peak) peak <= mag;
      end
      if (clr) peak <= 20'h00000;
    end
  end
endmodule : hasc_audio_model

/* sim/tb.sv */
// Self-checking testbench for the hearing-aid audio chain
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T32 = 8;
  localparam int T16 = 16;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [19:0] mic1_in;
  logic [19:0] mic2_in;
  logic [19:0] coil_in;
  logic [19:0] dac_data;
  logic        dac_valid;
  logic        clr;
  logic [2:0]  en;
  logic [19:0] peak;
  logic [15:0] gap;
  int          mismatches;
  int          check_count;

  hasc_chain #(.TICKS_32(T32), .TICKS_16(T16)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .mic1_in(mic1_in), .mic2_in(mic2_in),
    .coil_in(coil_in), .dac_data(dac_data), .dac_valid(dac_valid));

  hasc_audio_model far_end (
    .hclk(hclk), .hresetn(hresetn), .clr(clr), .en(en),
    .dac_data(dac_data), .dac_valid(dac_valid), .mic1_in(mic1_in),
    .mic2_in(mic2_in), .coil_in(coil_in), .peak(peak), .gap(gap));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // --------------------------------------------------------------
  // Checking and closing
  // --------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  // --------------------------------------------------------------
  // Bus and stream helpers
  // --------------------------------------------------------------
  task automatic bus_wait();
    int n;
    for (n = 0; n < 64; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 64) begin
      mismatches++;
      complete_run();
    end
  endtask : bus_wait

  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    bus_wait();
    htrans <= 2'b00;
    hwdata <= wd;
    bus_wait();
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(a, 1'b1, d, x);
  endtask : wr

  task automatic rdchk(input string nm, input logic [31:0] a, exp);
    logic [31:0] x;
    xfer(a, 1'b0, 32'h0, x);
    check(nm, x, exp);
  endtask : rdchk

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask : do_reset

  // Bounded: a stalled stream counts as a failure
  task automatic samples(input int k);
    int got;
    got = 0;
    for (int n = 0; n < k * T16 * 2 + 20 && got < k; n++) begin
      @(posedge hclk);
      if (dac_valid === 1'b1) got++;
    end
    if (got < k) begin
      mismatches++;
      complete_run();
    end
  endtask : samples

  // Fresh start, one setup, then the peak of 48 output samples
  task automatic run(input logic [31:0] ctrl, input logic [2:0] e,
                     input logic [31:0] vol);
    do_reset();
    en <= e;
    wr(32'(hasc_pkg::A_VOL), vol);
    wr(32'(hasc_pkg::A_NZ), 32'h00007FFF);
    wr(32'(hasc_pkg::A_CTRL), ctrl);
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    samples(48);
  endtask : run
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_regs();
    do_reset();
    rdchk("scnt", 32'(hasc_pkg::A_SCNT), 32'h0);
    rdchk("ctrl", 32'(hasc_pkg::A_CTRL), 32'h100);
    rdchk("wbg", 32'(hasc_pkg::A_WBG), 32'h1000);
    rdchk("vol", 32'(hasc_pkg::A_VOL), 32'h7FFF);
    rdchk("nz", 32'(hasc_pkg::A_NZ), 32'h0);
    rdchk("clip", 32'(hasc_pkg::A_CLIP), 32'h7FFFF);
    rdchk("thr", 32'(hasc_pkg::A_THR), 32'h40000);
    rdchk("nra", 32'(hasc_pkg::A_NRA), 32'h7FFF);
    rdchk("unmapped", 32'h200, 32'h0);
    for (int s = 0; s < 8; s++) begin
      rdchk("b0", 32'(hasc_pkg::A_COEF) + 32'(20 * s), 32'h4000);
      rdchk("a2", 32'(hasc_pkg::A_COEF) + 32'(20 * s + 16), 32'h0);
    end
  endtask : t_regs

  task automatic t_chan();
    int ch[5] = '{1, 2, 4, 6, 8};
    do_reset();
    foreach (ch[i]) begin
      wr(32'(hasc_pkg::A_CTRL), 32'(ch[i] << 5));
      rdchk("chan", 32'(hasc_pkg::A_CTRL), 32'(ch[i] << 5));
    end
    wr(32'(hasc_pkg::A_CTRL), 32'h64);
    rdchk("chan_bad", 32'(hasc_pkg::A_CTRL), 32'h104);
  endtask : t_chan

  task automatic t_rate();
    logic [31:0] a;
    logic [31:0] b;
    do_reset();
    samples(3);
    check("gap32", 32'(gap), 32'(T32));
    xfer(32'(hasc_pkg::A_SCNT), 1'b0, 32'h0, a);
    samples(4);
    xfer(32'(hasc_pkg::A_SCNT), 1'b0, 32'h0, b);
    check("scnt_step", b - a, 32'h4);
    wr(32'(hasc_pkg::A_CTRL), 32'h104);
    samples(3);
    check("gap16", 32'(gap), 32'(T16));
  endtask : t_rate

  task automatic t_src();
    run(32'h2, 3'b010, 32'h7FFF);
    check("mic2_mixed", 32'(peak != 0), 32'h1);
    run(32'h3, 3'b010, 32'h7FFF);
    check("mic2_unsel", 32'(peak != 0), 32'h0);
    run(32'h3, 3'b100, 32'h7FFF);
    check("coil_sel", 32'(peak != 0), 32'h1);
    run(32'h0, 3'b010, 32'h7FFF);
    check("mic2_unmixed", 32'(peak != 0), 32'h0);
    run(32'h0, 3'b001, 32'h7FFF);
    check("mic1_main", 32'(peak != 0), 32'h1);
  endtask : t_src

  task automatic t_clip();
    logic [31:0] x;
    logic [19:0] held;
    run(32'h0, 3'b001, 32'h7FFF);
    wr(32'(hasc_pkg::A_CLIP), 32'h100);
    // Samples clipped at the old level are still in the pipe
    samples(3);
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    samples(48);
    check("clip_bound", 32'(peak <= 20'h00100), 32'h1);
    check("clip_live", 32'(peak != 0), 32'h1);
    held = dac_data;
    xfer(32'(hasc_pkg::A_STAT), 1'b0, 32'h0, x);
    check("stat", x, 32'(held));
  endtask : t_clip

  // Volume zero hides noise added before it, not noise added after
  task automatic t_noise();
    for (int p = 0; p < 4; p++) begin
      run(32'(p << 3), 3'b000, 32'h0);
      check("noise_point", 32'(peak != 0), 32'(p == 2));
    end
    run(32'h8, 3'b000, 32'h7FFF);
    check("noise_pre_vol", 32'(peak != 0), 32'h1);
  endtask : t_noise

  initial begin
    mismatches  = 0;
    check_count = 0;
    hresetn     = 1'b0;
    hsel        = 1'b0;
    haddr       = 32'h0;
    htrans      = 2'b00;
    hwrite      = 1'b0;
    hsize       = 3'b010;
    hwdata      = 32'h0;
    clr         = 1'b0;
    en          = 3'b000;
    @(posedge hclk);
    t_regs();
    t_chan();
    t_rate();
    t_src();
    t_clip();
    t_noise();
    complete_run();
  end
endmodule : tb
